// *** design/cmdbus_term_ctrl.sv ***
// Controller end: programs termination and tracks calibration and training.
`timescale 1ns/1ps

module cmdbus_term_ctrl (
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  cmdbus_term_if.ctrl bus,
  input wire logic i_apply,
  input cmdbus_term_pkg::strength_t i_strength,
  input wire logic i_clock_force,
  input wire logic i_select_force,
  input wire logic i_cmdbus_disable,
  input wire logic i_high_pullup,
  input wire logic i_calib_done,
  input wire logic i_train_req,
  input wire logic i_train_terminating,
  output logic o_busy,
  output logic o_refused,
  output logic o_calib_needed,
  output logic o_train_grant,
  output logic o_train_refused
);
  import cmdbus_term_pkg::*;

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    ctrl_state_e st;
    logic mrw_valid;
    mode_addr_t mrw_addr;
    mode_data_t mrw_data;
    mode_data_t ovr_hold;
    logic refused;
    logic point;
    logic calib_needed;
    logic term_trained;
    logic grant;
    logic train_refused;
    logic busy;
  } ctrl_state_s;

  localparam ctrl_state_s CTRL_RESET = '{
    st: CTRL_IDLE,
    mrw_valid: 1'b0,
    mrw_addr: 6'h00,
    mrw_data: 8'h00,
    ovr_hold: 8'h00,
    refused: 1'b0,
    point: 1'b0,
    calib_needed: 1'b0,
    term_trained: 1'b0,
    grant: 1'b0,
    train_refused: 1'b0,
    busy: 1'b0
  };

  ctrl_state_s state_ff;
  ctrl_state_s nxt_state;
  logic forbidden_combo;
  logic point_changed;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    nxt_state = state_ff;
    nxt_state.mrw_valid = 1'b0;
    nxt_state.refused = 1'b0;
    nxt_state.grant = 1'b0;
    nxt_state.train_refused = 1'b0;

    forbidden_combo = state_ff.point &&
                      (i_strength >= `STRENGTH_FIRST_LOW_OHM) &&
                      strength_on(i_strength);
    point_changed = (i_high_pullup != state_ff.point);
    nxt_state.point = i_high_pullup;
    // A point change seen with a done pulse still needs calibration.
    nxt_state.calib_needed = point_changed ||
      (state_ff.calib_needed && !i_calib_done);

    case (state_ff.st)
      CTRL_IDLE: begin
        if (i_apply && forbidden_combo) begin
          nxt_state.refused = 1'b1;
        end else if (i_apply) begin
          nxt_state.mrw_valid = 1'b1;
          nxt_state.mrw_addr = `TERM_CONFIG_ADDR;
          nxt_state.mrw_data = {1'b0, i_strength, 4'h0};
          nxt_state.ovr_hold = {2'b00, i_cmdbus_disable, i_select_force,
                                i_clock_force, 3'b000};
          nxt_state.st = CTRL_SEND_OVR;
        end
      end
      CTRL_SEND_OVR: begin
        nxt_state.mrw_valid = 1'b1;
        nxt_state.mrw_addr = `TERM_OVERRIDE_ADDR;
        nxt_state.mrw_data = state_ff.ovr_hold;
        nxt_state.st = CTRL_FINISH;
      end
      CTRL_FINISH: begin
        nxt_state.st = CTRL_IDLE;
      end
      default: begin
        nxt_state.st = CTRL_IDLE;
      end
    endcase
    nxt_state.busy = (nxt_state.st != CTRL_IDLE);

    // The terminating rank must be trained before any other rank.
    if (i_train_req && i_train_terminating) begin
      nxt_state.grant = 1'b1;
      nxt_state.term_trained = 1'b1;
    end else if (i_train_req && state_ff.term_trained) begin
      nxt_state.grant = 1'b1;
    end else if (i_train_req) begin
      nxt_state.train_refused = 1'b1;
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      state_ff <= CTRL_RESET;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign bus.mrw_valid = state_ff.mrw_valid;
  assign bus.mrw_addr = state_ff.mrw_addr;
  assign bus.mrw_data = state_ff.mrw_data;
  assign o_busy = state_ff.busy;
  assign o_refused = state_ff.refused;
  assign o_calib_needed = state_ff.calib_needed;
  assign o_train_grant = state_ff.grant;
  assign o_train_refused = state_ff.train_refused;

endmodule : cmdbus_term_ctrl

// *** design/cmdbus_term_defines.svh ***
// Constants for the command-bus termination control design.
// Functional notes
// - Strength from config field; default disabled.
// - Applies to clock pair, select, six inputs.
// - Termination holds through power-down states.
// - Select pad low: no command/address termination.
// - Pad high and enabled: terminate at strength.
// - Field disabled: every group is off.
// - Pad low: clock, select follow force bits.
// - Pad high: disable bit turns off command/address.
// - Controller trains terminating rank first.
// - Termination change needs no recalibration.
// - Pull-up point change requires recalibration.
// - High pull-up point forbids 60/48/40 ohm.
// - Codes one to six enabled; others disabled.
// - Disable bit kills command/address termination.
// - Force bits terminate despite low pad.
`ifndef CMDBUS_TERM_DEFINES_SVH
`define CMDBUS_TERM_DEFINES_SVH

// ----------------------------------------
// Mode-register addresses
// ----------------------------------------
`define TERM_CONFIG_ADDR 6'h0b
`define TERM_OVERRIDE_ADDR 6'h16
`define SETPOINT_CTRL_ADDR 6'h0d

// ----------------------------------------
// Field positions
// ----------------------------------------
`define CFG_STRENGTH_MSB 6
`define CFG_STRENGTH_LSB 4
`define OVR_CLOCK_FORCE_BIT 3
`define OVR_SELECT_FORCE_BIT 4
`define OVR_CMD_DISABLE_BIT 5
`define SP_WRITE_BIT 6
`define SP_OPERATE_BIT 7

// ----------------------------------------
// Reset values and encodings
// ----------------------------------------
`define TERM_CONFIG_RESET 8'h00
`define TERM_OVERRIDE_RESET 8'h00
`define STRENGTH_FIRST_ON 3'h1
`define STRENGTH_LAST_ON 3'h6
`define STRENGTH_FIRST_LOW_OHM 3'h4

`endif

// *** design/cmdbus_term_dev.sv ***
// Memory-die end: stores termination settings and drives enables.
`timescale 1ns/1ps

module cmdbus_term_dev (
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  cmdbus_term_if.dev bus,
  input wire logic i_term_select_pad,
  input wire logic i_low_power,
  output logic o_clock_true_term_en,
  output logic o_clock_comp_term_en,
  output logic o_select_term_en,
  output logic [5:0] o_cmd_addr_term_en,
  output cmdbus_term_pkg::strength_t o_clock_strength,
  output cmdbus_term_pkg::strength_t o_select_strength,
  output cmdbus_term_pkg::strength_t o_cmd_addr_strength,
  output logic o_write_ignored
);
  import cmdbus_term_pkg::*;

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    mode_data_t [1:0] cfg;
    mode_data_t [1:0] ovr;
    logic sp_write;
    logic sp_operate;
    logic pad_meta;
    logic pad_sync;
    logic ck_on;
    logic cs_on;
    logic ca_on;
    strength_t ck_code;
    strength_t cs_code;
    strength_t ca_code;
    logic ignored;
  } dev_state_s;

  typedef struct packed {
    logic ck;
    logic cs;
    logic ca;
  } group_en_s;

  typedef enum {
    TGT_NONE, TGT_CONFIG, TGT_OVERRIDE, TGT_SETPOINT
  } write_tgt_e;

  localparam dev_state_s DEV_RESET = '{
    cfg: {`TERM_CONFIG_RESET, `TERM_CONFIG_RESET},
    ovr: {`TERM_OVERRIDE_RESET, `TERM_OVERRIDE_RESET},
    sp_write: 1'b0,
    sp_operate: 1'b0,
    pad_meta: 1'b0,
    pad_sync: 1'b0,
    ck_on: 1'b0,
    cs_on: 1'b0,
    ca_on: 1'b0,
    ck_code: 3'h0,
    cs_code: 3'h0,
    ca_code: 3'h0,
    ignored: 1'b0
  };

  dev_state_s state_ff;
  dev_state_s nxt_state;

  mode_data_t act_cfg;
  mode_data_t act_ovr;
  strength_t act_code;
  logic act_on;
  logic pad_high;
  logic ck_force;
  logic cs_force;
  logic ca_disable;
  logic wr_take;
  logic wr_drop;
  write_tgt_e tgt;
  group_en_s grp;

  // ----------------------------------------
  // Decode helpers
  // ----------------------------------------
  // Maps a mode-register address to the setting that it writes.
  function automatic write_tgt_e write_target(input mode_addr_t addr);
    if (addr == `TERM_CONFIG_ADDR) begin
      write_target = TGT_CONFIG;
    end else if (addr == `TERM_OVERRIDE_ADDR) begin
      write_target = TGT_OVERRIDE;
    end else if (addr == `SETPOINT_CTRL_ADDR) begin
      write_target = TGT_SETPOINT;
    end else begin
      write_target = TGT_NONE;
    end
  endfunction : write_target

  // Applies the command-bus state table to one active setting.
  function automatic group_en_s term_groups(input logic on,
                                            input logic pad,
                                            input logic ck_frc,
                                            input logic cs_frc,
                                            input logic ca_dis);
    if (!on) begin
      term_groups = '{ck: 1'b0, cs: 1'b0, ca: 1'b0};
    end else if (!pad) begin
      term_groups = '{ck: ck_frc, cs: cs_frc, ca: 1'b0};
    end else begin
      term_groups = '{ck: 1'b1, cs: 1'b1, ca: !ca_dis};
    end
  endfunction : term_groups

  // ----------------------------------------
  // Write decode
  // ----------------------------------------
  // Only writes made while the die is awake reach the settings.
  always_comb begin
    wr_take = bus.mrw_valid && !i_low_power;
    wr_drop = bus.mrw_valid && i_low_power;
    tgt = wr_take ? write_target(bus.mrw_addr) : TGT_NONE;
  end

  // ----------------------------------------
  // Active set point decode
  // ----------------------------------------
  always_comb begin
    act_cfg = state_ff.cfg[state_ff.sp_operate];
    act_ovr = state_ff.ovr[state_ff.sp_operate];
    act_code = act_cfg[`CFG_STRENGTH_MSB:`CFG_STRENGTH_LSB];
    act_on = strength_on(act_code);
    pad_high = state_ff.pad_sync;
    ck_force = act_ovr[`OVR_CLOCK_FORCE_BIT];
    cs_force = act_ovr[`OVR_SELECT_FORCE_BIT];
    ca_disable = act_ovr[`OVR_CMD_DISABLE_BIT];
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    nxt_state = state_ff;
    nxt_state.pad_meta = i_term_select_pad;
    nxt_state.pad_sync = state_ff.pad_meta;
    nxt_state.ignored = wr_drop;

    // Writes are refused while the die sleeps, so the settings and
    // the enables derived from them stand unchanged through it.
    case (tgt)
      TGT_CONFIG: begin
        nxt_state.cfg[state_ff.sp_write] = bus.mrw_data;
      end
      TGT_OVERRIDE: begin
        nxt_state.ovr[state_ff.sp_write] = bus.mrw_data;
      end
      TGT_SETPOINT: begin
        nxt_state.sp_write = bus.mrw_data[`SP_WRITE_BIT];
        nxt_state.sp_operate = bus.mrw_data[`SP_OPERATE_BIT];
      end
      default: begin
      end
    endcase

    // Enables follow the stored settings, never the power state.
    grp = term_groups(act_on, pad_high, ck_force, cs_force, ca_disable);
    nxt_state.ck_on = grp.ck;
    nxt_state.cs_on = grp.cs;
    nxt_state.ca_on = grp.ca;

    // Each group reports the strength that it terminates with.
    nxt_state.ck_code = grp.ck ? act_code : 3'h0;
    nxt_state.cs_code = grp.cs ? act_code : 3'h0;
    nxt_state.ca_code = grp.ca ? act_code : 3'h0;
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      state_ff <= DEV_RESET;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign o_clock_true_term_en = state_ff.ck_on;
  assign o_clock_comp_term_en = state_ff.ck_on;
  assign o_select_term_en = state_ff.cs_on;

  genvar gi;
  generate
    for (gi = 0; gi < 6; gi++) begin : g_ca
      assign o_cmd_addr_term_en[gi] = state_ff.ca_on;
    end
  endgenerate

  assign o_clock_strength = state_ff.ck_code;
  assign o_select_strength = state_ff.cs_code;
  assign o_cmd_addr_strength = state_ff.ca_code;
  assign o_write_ignored = state_ff.ignored;

endmodule : cmdbus_term_dev

// *** design/cmdbus_term_if.sv ***
// Mode-register write channel between controller and memory die.
`timescale 1ns/1ps

interface cmdbus_term_if;
  logic mrw_valid;
  logic [5:0] mrw_addr;
  logic [7:0] mrw_data;

  modport ctrl (output mrw_valid, output mrw_addr, output mrw_data);
  modport dev (input mrw_valid, input mrw_addr, input mrw_data);
endinterface : cmdbus_term_if

// *** design/cmdbus_term_pkg.sv ***
// Types and decode helpers for the command-bus termination design.
`include "cmdbus_term_defines.svh"

package cmdbus_term_pkg;

  typedef logic [2:0] strength_t;
  typedef logic [7:0] mode_data_t;
  typedef logic [5:0] mode_addr_t;

  typedef enum logic [2:0] {
    STR_OFF, STR_240, STR_120, STR_80, STR_60, STR_48, STR_40, STR_RSVD
  } strength_e;

  typedef enum logic [1:0] {CTRL_IDLE, CTRL_SEND_OVR, CTRL_FINISH} ctrl_state_e;

  // True when the strength code selects a real termination value.
  function automatic logic strength_on(input strength_t code);
    strength_on = (code >= `STRENGTH_FIRST_ON) &&
                  (code <= `STRENGTH_LAST_ON);
  endfunction : strength_on

endpackage : cmdbus_term_pkg

// *** verif/cmdbus_term_monitor.sv ***
// Checker for the mode-register channel and the termination outputs.
`timescale 1ns/1ps

module cmdbus_term_monitor (
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  input wire logic mrw_valid,
  input wire logic [5:0] mrw_addr,
  input wire logic [7:0] mrw_data,
  input wire logic o_clock_true_term_en,
  input wire logic o_clock_comp_term_en,
  input wire logic o_select_term_en,
  input wire logic [5:0] o_cmd_addr_term_en,
  input wire cmdbus_term_pkg::strength_t o_clock_strength,
  input wire cmdbus_term_pkg::strength_t o_select_strength,
  input wire logic o_busy,
  input wire logic o_refused
);
  import cmdbus_term_pkg::*;
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_resetn);
  sequence s_cfg; mrw_valid && mrw_addr == 6'h0b; endsequence
  sequence s_ovr; mrw_valid && mrw_addr == 6'h16; endsequence
  cfg_then_ovr_a: assert property (s_cfg |=> s_ovr ##1 !mrw_valid)
    else $error("override write did not follow config write");
  busy_span_a: assert property (s_cfg |-> o_busy [*2] ##1 !o_busy)
    else $error("busy span wrong around a programming sequence");
  cfg_format_a: assert property (s_cfg |-> mrw_data[3:0] == 4'h0)
    else $error("config write carries bits outside the field");
  ovr_format_a: assert property (s_ovr |-> mrw_data[2:0] == 3'h0)
    else $error("override write carries stray low bits");
  pair_same_a: assert property (o_clock_true_term_en == o_clock_comp_term_en
    && o_cmd_addr_term_en inside {6'h00, 6'h3f})
    else $error("clock pair or address lines disagree");
  ca_needs_all_a: assert property (o_cmd_addr_term_en[0]
    |-> o_clock_true_term_en && o_select_term_en)
    else $error("address on without clock and select");
  strength_on_a: assert property ((o_clock_strength != 3'h0)
    == o_clock_true_term_en && o_clock_strength != 3'h7)
    else $error("clock strength does not match its enable");
  same_str_a: assert property (o_clock_true_term_en && o_select_term_en
    |-> o_select_strength == o_clock_strength)
    else $error("select and clock strengths differ");
  refuse_quiet_a: assert property (o_refused |-> !mrw_valid ##1 !mrw_valid)
    else $error("refused request still wrote");
endmodule : cmdbus_term_monitor

// *** verif/test_command_bus_termination_ctrl.sv ***
// Testbench joining the controller end and the die end.
`timescale 1ns/1ps

module test_command_bus_termination_ctrl;
  import cmdbus_term_pkg::*;
  logic i_sys_clk = 1'b0;
  logic i_resetn = 1'b0;
  logic pad = 1'b0, low_pwr = 1'b0, apply = 1'b0, hi_pu = 1'b0;
  logic clk_frc = 1'b0, sel_frc = 1'b0, ca_dis = 1'b0;
  logic cal_done = 1'b0, trn_req = 1'b0, trn_term = 1'b0;
  strength_t code = 3'h0;
  logic ck_t, ck_c, cs_en, wr_ign, busy, refused, cal_need, grant, t_ref;
  logic [5:0] ca_en;
  strength_t ck_s, cs_s, ca_s;
  int n_mismatch = 0, checks_done = 0;
  int n_ign = 0, n_ref = 0, n_grant = 0, n_tref = 0;

  initial forever #12.5 i_sys_clk = ~i_sys_clk;

  cmdbus_term_if u_cmdbus_term_if ();
  cmdbus_term_dev u_cmdbus_term_dev (.i_sys_clk(i_sys_clk),
    .i_resetn(i_resetn), .bus(u_cmdbus_term_if), .i_term_select_pad(pad),
    .i_low_power(low_pwr), .o_clock_true_term_en(ck_t),
    .o_clock_comp_term_en(ck_c), .o_select_term_en(cs_en),
    .o_cmd_addr_term_en(ca_en), .o_clock_strength(ck_s),
    .o_select_strength(cs_s), .o_cmd_addr_strength(ca_s),
    .o_write_ignored(wr_ign));
  cmdbus_term_ctrl u_cmdbus_term_ctrl (.i_sys_clk(i_sys_clk),
    .i_resetn(i_resetn), .bus(u_cmdbus_term_if), .i_apply(apply),
    .i_strength(code), .i_clock_force(clk_frc), .i_select_force(sel_frc),
    .i_cmdbus_disable(ca_dis), .i_high_pullup(hi_pu),
    .i_calib_done(cal_done), .i_train_req(trn_req),
    .i_train_terminating(trn_term), .o_busy(busy), .o_refused(refused),
    .o_calib_needed(cal_need), .o_train_grant(grant),
    .o_train_refused(t_ref));
  cmdbus_term_monitor u_mon (.i_sys_clk(i_sys_clk), .i_resetn(i_resetn),
    .mrw_valid(u_cmdbus_term_if.mrw_valid),
    .mrw_addr(u_cmdbus_term_if.mrw_addr),
    .mrw_data(u_cmdbus_term_if.mrw_data), .o_clock_true_term_en(ck_t),
    .o_clock_comp_term_en(ck_c), .o_select_term_en(cs_en),
    .o_cmd_addr_term_en(ca_en), .o_clock_strength(ck_s),
    .o_select_strength(cs_s), .o_busy(busy), .o_refused(refused));

  always @(posedge i_sys_clk) begin
    n_ign <= n_ign + int'(wr_ign === 1'b1);
    n_ref <= n_ref + int'(refused === 1'b1);
    n_grant <= n_grant + int'(grant === 1'b1);
    n_tref <= n_tref + int'(t_ref === 1'b1);
  end

  task automatic check(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic final_report;
    $display("Checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : final_report

  task automatic prog(input strength_t c, input logic k, s, d);
    int i;
    @(posedge i_sys_clk);
    apply <= 1'b1;
    code <= c;
    clk_frc <= k;
    sel_frc <= s;
    ca_dis <= d;
    @(posedge i_sys_clk);
    apply <= 1'b0;
    for (i = 0; i < 20; i++) begin
      @(negedge i_sys_clk);
      if (busy === 1'b0) break;
    end
    if (i == 20) begin
      n_mismatch++;
      final_report();
    end
    repeat (3) @(posedge i_sys_clk);
    @(negedge i_sys_clk);
  endtask : prog

  task automatic expect_out(input strength_t c, input logic p, k, s, d);
    logic on;
    logic [2:0] e;
    on = c >= 3'h1 && c <= 3'h6;
    e[2] = on && p && !d;
    e[1] = on && (p || k);
    e[0] = on && (p || s);
    check("ca_en", {2'h0, ca_en}, e[2] ? 8'h3f : 8'h00);
    check("ck pair", {6'h0, ck_t, ck_c}, {6'h0, e[1], e[1]});
    check("cs_en", {7'h0, cs_en}, {7'h0, e[0]});
    check("ck_s", {5'h0, ck_s}, e[1] ? {5'h0, c} : 8'h00);
    check("cs_s", {5'h0, cs_s}, e[0] ? {5'h0, c} : 8'h00);
    check("ca_s", {5'h0, ca_s}, e[2] ? {5'h0, c} : 8'h00);
  endtask : expect_out

  task automatic t_codes;
    @(posedge i_sys_clk);
    pad <= 1'b1;
    for (int c = 0; c < 8; c++) begin
      prog(3'(c), 1'b0, 1'b0, 1'b0);
      expect_out(3'(c), 1'b1, 1'b0, 1'b0, 1'b0);
    end
    $display("test codes done");
  endtask : t_codes

  task automatic t_pad_low;
    @(posedge i_sys_clk);
    pad <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      prog(3'h2, i[1], i[0], 1'b0);
      expect_out(3'h2, 1'b0, i[1], i[0], 1'b0);
    end
    prog(3'h0, 1'b1, 1'b1, 1'b0);
    expect_out(3'h0, 1'b0, 1'b1, 1'b1, 1'b0);
    $display("test pad low done");
  endtask : t_pad_low

  task automatic t_disable;
    @(posedge i_sys_clk);
    pad <= 1'b1;
    prog(3'h3, 1'b0, 1'b0, 1'b1);
    expect_out(3'h3, 1'b1, 1'b0, 1'b0, 1'b1);
    $display("test disable done");
  endtask : t_disable

  task automatic t_low_power;
    int c0;
    prog(3'h1, 1'b0, 1'b0, 1'b0);
    @(posedge i_sys_clk);
    low_pwr <= 1'b1;
    c0 = n_ign;
    prog(3'h0, 1'b0, 1'b0, 1'b0);
    check("ignored", 8'(n_ign - c0), 8'h02);
    expect_out(3'h1, 1'b1, 1'b0, 1'b0, 1'b0);
    @(posedge i_sys_clk);
    low_pwr <= 1'b0;
    $display("test low power done");
  endtask : t_low_power

  task automatic t_calib;
    int r0;
    @(posedge i_sys_clk);
    hi_pu <= 1'b1;
    repeat (3) @(posedge i_sys_clk);
    @(negedge i_sys_clk);
    check("cal_need", {7'h0, cal_need}, 8'h01);
    r0 = n_ref;
    prog(3'h5, 1'b0, 1'b0, 1'b0);
    check("refused", 8'(n_ref - r0), 8'h01);
    expect_out(3'h1, 1'b1, 1'b0, 1'b0, 1'b0);
    @(posedge i_sys_clk);
    cal_done <= 1'b1;
    @(posedge i_sys_clk);
    cal_done <= 1'b0;
    prog(3'h2, 1'b0, 1'b0, 1'b0);
    expect_out(3'h2, 1'b1, 1'b0, 1'b0, 1'b0);
    check("cal_clear", {7'h0, cal_need}, 8'h00);
    $display("test calibration done");
  endtask : t_calib

  task automatic t_reset;
    @(posedge i_sys_clk);
    i_resetn <= 1'b0;
    repeat (2) @(posedge i_sys_clk);
    i_resetn <= 1'b1;
    @(negedge i_sys_clk);
    expect_out(3'h0, 1'b1, 1'b0, 1'b0, 1'b0);
    $display("test reset done");
  endtask : t_reset

  task automatic train(input logic t);
    @(posedge i_sys_clk);
    trn_req <= 1'b1;
    trn_term <= t;
    @(posedge i_sys_clk);
    trn_req <= 1'b0;
    repeat (3) @(posedge i_sys_clk);
  endtask : train

  task automatic t_train;
    train(1'b0);
    check("t_refused", 8'(n_tref), 8'h01);
    train(1'b1);
    train(1'b0);
    check("grants", 8'(n_grant), 8'h02);
    $display("test training done");
  endtask : t_train

  initial begin
    repeat (10) @(posedge i_sys_clk);
    i_resetn <= 1'b1;
    repeat (2) @(posedge i_sys_clk);
    @(negedge i_sys_clk);
    expect_out(3'h0, 1'b0, 1'b0, 1'b0, 1'b0);
    t_train();
    t_codes();
    t_pad_low();
    t_disable();
    t_low_power();
    t_calib();
    t_reset();
    final_report();
  end
endmodule : test_command_bus_termination_ctrl
